// >>> hw/mic_consts.vh
// constants of the interrupt controller: register indexes, reset values, vectors
// assumes byte address = 4 * index on the register bus
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH

`define MIC_IDX_EDGE_SEL 16'hFFF2
`define MIC_IDX_EN_A 16'hFFF3
`define MIC_IDX_EN_B 16'hFFF4
`define MIC_IDX_FLAGS_A 16'hFFF6
`define MIC_IDX_FLAGS_B 16'hFFF7
`define MIC_IDX_WAKE_FLAGS 16'hFFF9
`define MIC_IDX_GLOBAL_MASK 16'hFFF0
`define MIC_IDX_VECTOR 16'hFFF1

`define MIC_RST_EDGE_SEL 8'hE0
`define MIC_RST_EN 8'h00
`define MIC_RST_FLAGS_A 8'h20
`define MIC_RST_FLAGS_B 8'h00
`define MIC_RST_WAKE 8'h00
`define MIC_RST_MASK 1'h1

`define MIC_EDGE_SEL_FIXED 8'hE0
`define MIC_FA_OVF 7
`define MIC_FA_SER1 6
`define MIC_FA_WAKE 5
`define MIC_FB_DIRECT 7
`define MIC_FB_CONV 6
`define MIC_FB_CAPT 4
`define MIC_FB_HIGH 3
`define MIC_FB_LOW 2
`define MIC_FB_USED 8'hDC

`define MIC_VEC_EDGE0 5'h04
`define MIC_VEC_WAKE 5'h09
`define MIC_VEC_SER1 5'h0A
`define MIC_VEC_OVF 5'h0B
`define MIC_VEC_LOW 5'h0E
`define MIC_VEC_HIGH 5'h0F
`define MIC_VEC_CAPT 5'h10
`define MIC_VEC_SER3 5'h12
`define MIC_VEC_CONV 5'h13
`define MIC_VEC_DIRECT 5'h14

`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2

`endif

// >>> hw/mic_interrupt_ctrl.v
// interrupt controller: pin edge/wake detection, request flags, enables, fixed-priority vector
// assumes pins are asynchronous, peripheral requests other than the serial-three level are core_clk pulses, AXI4-Lite master on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module mic_interrupt_ctrl #(
  parameter ADDR_W = 18
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // pins
  input wire [4:0] edgeInPin,
  input wire [7:0] wakeInPinN,
  input wire [4:0] edgePinIntMode,
  // peripheral requests, one-cycle pulses except the serial-three level
  input wire ovfTimerReq,
  input wire serialOneReq,
  input wire [1:0] lowTimerReq,
  input wire [1:0] highTimerReq,
  input wire [1:0] captureReq,
  input wire [5:0] serialThreeReq,
  input wire convEndReq,
  input wire directXferReq,
  // cpu side
  output reg intReq_r,
  output reg [4:0] vecNum_r,
  output reg [15:0] vecAddr_r,
  output reg [4:0] edgeSel_r,
  // axi4-lite write
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  reg [12:0] pinMeta_r;
  reg [12:0] pinSync_r;
  reg [12:0] pinPrev_r;
  wire [4:0] edgeHit;
  wire [7:0] wakeHit;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // idle high, so a released reset does not fake a falling edge
      pinMeta_r <= 13'h1FFF;
      pinSync_r <= 13'h1FFF;
      pinPrev_r <= 13'h1FFF;
    end else begin
      pinMeta_r <= {wakeInPinN, edgeInPin};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : gEdge
      wire rise = pinSync_r[g] & ~pinPrev_r[g];
      wire fall = ~pinSync_r[g] & pinPrev_r[g];
      // edgeSel_r also drives the shared converter-trigger and timer-event pins
      // a pin left in port mode never sets its flag, whatever edge it sees
      assign edgeHit[g] = edgePinIntMode[g] & (edgeSel_r[g] ? rise : fall);
    end
    for (g = 0; g < 8; g = g + 1) begin : gWake
      // wake pins are active low, so a falling edge requests
      assign wakeHit[g] = ~pinSync_r[5+g] & pinPrev_r[5+g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] enA_r;
  reg [7:0] enB_r;
  reg [7:0] flagsA_r;
  reg [7:0] flagsB_r;
  reg [7:0] wakeFlags_r;
  reg globalMask_r;
  localparam [7:0] EDGE_SEL_RST = `MIC_RST_EDGE_SEL;
  reg [7:0] flagsA_nxt;
  reg [7:0] flagsB_nxt;
  reg [7:0] wakeFlags_nxt;
  reg [7:0] setA;
  reg [7:0] setB;

  // axi write channel holding
  reg awHeld_r;
  reg wHeld_r;
  reg [15:0] wIdx_r;
  reg [7:0] wByte_r;
  reg wLane_r;
  wire doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;
  // byte lane 0 carries the register; a write without it answers but changes nothing
  wire wStrobe = doWrite & wLane_r;
  // one select per register, shared by the strobes and the error response
  wire selEdge = wIdx_r == `MIC_IDX_EDGE_SEL;
  wire selEnA = wIdx_r == `MIC_IDX_EN_A;
  wire selEnB = wIdx_r == `MIC_IDX_EN_B;
  wire selFlagsA = wIdx_r == `MIC_IDX_FLAGS_A;
  wire selFlagsB = wIdx_r == `MIC_IDX_FLAGS_B;
  wire selWake = wIdx_r == `MIC_IDX_WAKE_FLAGS;
  wire selMask = wIdx_r == `MIC_IDX_GLOBAL_MASK;
  wire selVec = wIdx_r == `MIC_IDX_VECTOR;
  wire [7:0] clrA = (wStrobe && selFlagsA) ? ~wByte_r : 8'h00;
  wire [7:0] clrB = (wStrobe && selFlagsB) ? ~wByte_r : 8'h00;
  wire [7:0] clrW = (wStrobe && selWake) ? ~wByte_r : 8'h00;

  always @* begin
    setA = 8'h00;
    setA[`MIC_FA_OVF] = ovfTimerReq;
    setA[`MIC_FA_SER1] = serialOneReq;
    setA[4:0] = edgeHit;
    setB = 8'h00;
    setB[`MIC_FB_DIRECT] = directXferReq;
    setB[`MIC_FB_CONV] = convEndReq;
    setB[`MIC_FB_CAPT] = |captureReq;
    setB[`MIC_FB_HIGH] = |highTimerReq;
    setB[`MIC_FB_LOW] = |lowTimerReq;
    // set wins over a clear in the same cycle; flags set even while masked
    flagsA_nxt = (flagsA_r & ~clrA) | setA;
    // bit 5 of flags a has no source of its own and always reads one
    flagsA_nxt[`MIC_FA_WAKE] = 1'b1;
    flagsB_nxt = ((flagsB_r & ~clrB) | setB) & `MIC_FB_USED;
    wakeFlags_nxt = (wakeFlags_r & ~clrW) | wakeHit;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edgeSel_r <= EDGE_SEL_RST[4:0];
      enA_r <= `MIC_RST_EN;
      enB_r <= `MIC_RST_EN;
      globalMask_r <= `MIC_RST_MASK;
      flagsA_r <= `MIC_RST_FLAGS_A;
      flagsB_r <= `MIC_RST_FLAGS_B;
      wakeFlags_r <= `MIC_RST_WAKE;
    end else begin
      // acceptance never touches the flags, only software clears
      flagsA_r <= flagsA_nxt;
      flagsB_r <= flagsB_nxt;
      wakeFlags_r <= wakeFlags_nxt;
      if (wStrobe) begin
        if (selEdge)
          edgeSel_r <= wByte_r[4:0];
        if (selEnA)
          enA_r <= wByte_r;
        if (selEnB)
          enB_r <= wByte_r;
        if (selMask)
          globalMask_r <= wByte_r[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // arbitration, highest fixed priority first
  reg [4:0] winVec;
  reg winAny;
  wire wakeAny = |wakeFlags_r;
  wire [4:0] edgeElig = flagsA_r[4:0] & enA_r[4:0];
  // per-source eligibility: flag and enable both set
  wire eligWake = wakeAny & enA_r[`MIC_FA_WAKE];
  wire eligSer1 = flagsA_r[`MIC_FA_SER1] & enA_r[`MIC_FA_SER1];
  wire eligOvf = flagsA_r[`MIC_FA_OVF] & enA_r[`MIC_FA_OVF];
  wire eligLow = flagsB_r[`MIC_FB_LOW] & enB_r[`MIC_FB_LOW];
  wire eligHigh = flagsB_r[`MIC_FB_HIGH] & enB_r[`MIC_FB_HIGH];
  wire eligCapt = flagsB_r[`MIC_FB_CAPT] & enB_r[`MIC_FB_CAPT];
  wire eligConv = flagsB_r[`MIC_FB_CONV] & enB_r[`MIC_FB_CONV];
  wire eligDirect = flagsB_r[`MIC_FB_DIRECT] & enB_r[`MIC_FB_DIRECT];
  // serial-three flags and enables live in that unit, so its request level stands for both
  wire eligSer3 = |serialThreeReq;
  integer i;

  always @* begin
    winAny = 1'b0;
    winVec = 5'h00;
    if (!globalMask_r) begin
      winAny = 1'b1;
      if (|edgeElig) begin
        winVec = `MIC_VEC_EDGE0;
        for (i = 4; i >= 0; i = i - 1)
          if (edgeElig[i])
            winVec = `MIC_VEC_EDGE0 + i[4:0];
      end else if (eligWake)
        winVec = `MIC_VEC_WAKE;
      else if (eligSer1)
        winVec = `MIC_VEC_SER1;
      else if (eligOvf)
        winVec = `MIC_VEC_OVF;
      else if (eligLow)
        winVec = `MIC_VEC_LOW;
      else if (eligHigh)
        winVec = `MIC_VEC_HIGH;
      else if (eligCapt)
        winVec = `MIC_VEC_CAPT;
      else if (eligSer3)
        winVec = `MIC_VEC_SER3;
      else if (eligConv)
        winVec = `MIC_VEC_CONV;
      else if (eligDirect)
        winVec = `MIC_VEC_DIRECT;
      else
        winAny = 1'b0;
    end
  end

  // registered so the core sees one stable vector; costs one cycle of latency
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intReq_r <= 1'b0;
      vecNum_r <= 5'h00;
      vecAddr_r <= 16'h0000;
    end else begin
      intReq_r <= winAny;
      // winVec only ever holds table values, so vectors 1 to 3 cannot come out
      vecNum_r <= winAny ? winVec : 5'h00;
      vecAddr_r <= winAny ? {10'h000, winVec, 1'b0} : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path
  wire wIdxMapped = selEdge | selEnA | selEnB | selFlagsA | selFlagsB | selWake | selMask | selVec;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      wIdx_r <= 16'h0000;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MIC_RESP_OKAY;
    end else begin
      // ready pulses one cycle, so a valid still held is never taken twice
      s_axi_awready <= ~awHeld_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~wHeld_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        wIdx_r <= s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wByte_r <= s_axi_wdata[7:0];
        wLane_r <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wIdxMapped ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  wire [15:0] rIdx = s_axi_araddr[17:2];
  reg [7:0] rByte;
  reg rHit;

  always @* begin
    rHit = 1'b1;
    case (rIdx)
      `MIC_IDX_EDGE_SEL: rByte = `MIC_EDGE_SEL_FIXED | {3'h0, edgeSel_r};
      `MIC_IDX_EN_A: rByte = enA_r;
      `MIC_IDX_EN_B: rByte = enB_r;
      `MIC_IDX_FLAGS_A: rByte = flagsA_r;
      `MIC_IDX_FLAGS_B: rByte = flagsB_r;
      `MIC_IDX_WAKE_FLAGS: rByte = wakeFlags_r;
      `MIC_IDX_GLOBAL_MASK: rByte = {7'h00, globalMask_r};
      `MIC_IDX_VECTOR: rByte = {intReq_r, 2'h0, vecNum_r};
      default: begin
        rByte = 8'h00;
        rHit = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MIC_RESP_OKAY;
    end else begin
      // arready waits for rvalid to drop: one read in flight at a time
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rByte};
        s_axi_rresp <= rHit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> bench/mic_properties.sv
// checker for the interrupt controller: vector outputs and register bus timing
// assumes bind into mic_interrupt_ctrl, one clock core_clk, async reset rst
`timescale 1ns/1ps
`default_nettype none
module mic_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // cpu side
  input wire logic intReq_r,
  input wire logic [4:0] vecNum_r,
  input wire logic [15:0] vecAddr_r,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////
  a_vec_word_addr:
    assert property (vecAddr_r == {10'h000, vecNum_r, 1'b0}) else $error("vector address wrong");
  a_idle_vec_zero:
    assert property (!intReq_r |-> vecNum_r == 5'h00) else $error("vector without request");
  a_no_reserved_vec:
    assert property (intReq_r |-> vecNum_r inside {[5'h04:5'h0B], [5'h0E:5'h10], [5'h12:5'h14]})
      else $error("reserved vector issued");
  // the mask is only cleared by a bus write, which can finish inside these 8 cycles, so this relies on the bench writing later
  a_mask_after_rst:
    assert property ($fell(rst) |-> !intReq_r [*8]) else $error("request right after reset");
  a_wr_resp_time:
    assert property (wrTaken |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_rd_resp_time:
    assert property (rdTaken |-> ##[1:2] s_axi_rvalid) else $error("read data late");
  a_aw_ready_pulse:
    assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  a_rd_single_beat:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid repeated");
endmodule
bind mic_interrupt_ctrl mic_props mic_props_i (.core_clk(core_clk), .rst(rst), .intReq_r(intReq_r),
  .vecNum_r(vecNum_r), .vecAddr_r(vecAddr_r), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire

// >>> bench/mic_periph_model.sv
// peripheral request sources: one-cycle set pulses and the serial-three level
// assumes fire and ser3Hold change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module mic_periph_model (
  // clock and commands
  input wire logic core_clk,
  input wire logic [9:0] fire,
  input wire logic ser3Hold,
  // requests into the controller
  output logic ovfTimerReq,
  output logic serialOneReq,
  output logic [1:0] lowTimerReq,
  output logic [1:0] highTimerReq,
  output logic [1:0] captureReq,
  output logic convEndReq,
  output logic directXferReq,
  output logic [5:0] serialThreeReq
);
  // registered so each pulse lasts exactly as many core_clk cycles as its fire bit is held
  always @(posedge core_clk) begin
    {directXferReq, convEndReq, captureReq, highTimerReq, lowTimerReq, serialOneReq, ovfTimerReq} <= fire;
    serialThreeReq <= ser3Hold ? 6'h3F : 6'h00;
  end
endmodule
`default_nettype wire

// >>> bench/tb_mcu_interrupt_controller.sv
// bench for the interrupt controller: reset values, edge select, masking, priority walk
// assumes the AXI4-Lite slave of the design and the peripheral model beside it
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_interrupt_controller;
  logic core_clk = 1'b0, rst = 1'b1, ser3Hold = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [4:0] edgeInPin = 5'h1F, edgePinIntMode = 5'h1F;
  logic [7:0] wakeInPinN = 8'hFF, es;
  logic [9:0] fire = 10'h000;
  logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [4:0] vn [0:13];
  logic [15:0] cw [0:13];
  wire ovfTimerReq, serialOneReq, convEndReq, directXferReq, intReq_r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] lowTimerReq, highTimerReq, captureReq, s_axi_bresp, s_axi_rresp;
  wire [5:0] serialThreeReq;
  wire [4:0] vecNum_r, edgeSel_r;
  wire [15:0] vecAddr_r;
  wire [31:0] s_axi_rdata;
  integer errors = 0, tests_run = 0, seed = 32'hDD89, k;
  mic_interrupt_ctrl mic_interrupt_ctrl_i (
    .core_clk(core_clk), .rst(rst), .edgeInPin(edgeInPin), .wakeInPinN(wakeInPinN),
    .edgePinIntMode(edgePinIntMode), .ovfTimerReq(ovfTimerReq), .serialOneReq(serialOneReq),
    .lowTimerReq(lowTimerReq), .highTimerReq(highTimerReq), .captureReq(captureReq),
    .serialThreeReq(serialThreeReq), .convEndReq(convEndReq), .directXferReq(directXferReq),
    .intReq_r(intReq_r), .vecNum_r(vecNum_r), .vecAddr_r(vecAddr_r), .edgeSel_r(edgeSel_r),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  mic_periph_model mic_periph_model_i (.core_clk(core_clk), .fire(fire), .ser3Hold(ser3Hold),
    .ovfTimerReq(ovfTimerReq), .serialOneReq(serialOneReq), .lowTimerReq(lowTimerReq),
    .highTimerReq(highTimerReq), .captureReq(captureReq), .convEndReq(convEndReq),
    .directXferReq(directXferReq), .serialThreeReq(serialThreeReq));
  always #2 core_clk = ~core_clk;
  ////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] v);
    begin
      s_axi_awaddr <= {a, 2'h0};
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
    end
  endtask
  // e[9] set means an error answer is expected, whose data is not looked at
  task rc(input [15:0] a, input [9:0] e);
    begin
      s_axi_araddr <= {a, 2'h0};
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk({s_axi_rresp, s_axi_rdata[7:0] & {8{~e[9]}}}, e);
    end
  endtask
  task vc(input [4:0] e);
    begin
      repeat (8) @(posedge core_clk);
      chk({intReq_r, vecNum_r, vecAddr_r}, {e != 5'h00, e, 10'h000, e, 1'b0});
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    vn = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h10, 5'h12, 5'h13, 5'h14};
    cw = '{16'hF6FE, 16'hF6FD, 16'hF6FB, 16'hF6F7, 16'hF6EF, 16'hF900, 16'hF6BF, 16'hF67F, 16'hF7FB,
           16'hF7F7, 16'hF7EF, 16'h0000, 16'hF7BF, 16'hF77F};
    es = $random(seed);
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rc(16'hFFF2, 10'h0E0);
    rc(16'hFFF3, 10'h000);
    rc(16'hFFF6, 10'h020);
    rc(16'hFFF0, 10'h001);
    rc(16'hFFF5, 10'h200);
    wr(16'hFFF5, 8'h00);
    chk(s_axi_bresp, 32'h2);
    wr(16'hFFF2, es);
    chk(s_axi_bresp, 32'h0);
    rc(16'hFFF2, {2'h0, 3'b111, es[4:0]});
    chk(edgeSel_r, es[4:0]);
    wr(16'hFFF7, 8'hFF);
    rc(16'hFFF7, 10'h000);
    wr(16'hFFF3, 8'hFF);
    wr(16'hFFF4, 8'hFF);
    // unselected edge first, so a flag here would mean the polarity is ignored
    edgeInPin <= ~es[4:0];
    repeat (8) @(posedge core_clk);
    edgeInPin <= es[4:0];
    wakeInPinN <= ~(8'h01 << es[7:5]);
    fire <= {2'b11, es[2], ~es[2], es[1], ~es[1], es[0], ~es[0], 2'b11};
    ser3Hold <= 1'b1;
    @(posedge core_clk);
    fire <= 10'h000;
    vc(5'h00);
    rc(16'hFFF6, 10'h0FF);
    rc(16'hFFF7, 10'h0DC);
    rc(16'hFFF9, {2'h0, 8'h01 << es[7:5]});
    wr(16'hFFF0, 8'h00);
    for (k = 0; k < 14; k = k + 1) begin
      vc(vn[k]);
      if (k == 0) rc(16'hFFF6, 10'h0FF);
      if (vn[k] == 5'h12) ser3Hold <= 1'b0;
      else wr({8'hFF, cw[k][15:8]}, cw[k][7:0]);
    end
    vc(5'h00);
    // pins out of interrupt mode see both edges; both gated timer and serial sources fire
    edgePinIntMode <= 5'h00;
    wr(16'hFFF3, 8'h3F);
    edgeInPin <= ~es[4:0];
    repeat (8) @(posedge core_clk);
    edgeInPin <= es[4:0];
    fire <= 10'h003;
    @(posedge core_clk);
    fire <= 10'h000;
    vc(5'h00);
    rc(16'hFFF6, 10'h0E0);
    complete_run;
  end
  initial begin
    #20000;
    errors = errors + 1;
    complete_run;
  end
endmodule
`default_nettype wire
